// ==== pkg/uafc_pkg.sv ====
package uafc_pkg;

  // Enhanced feature register bit positions
  localparam int EFR_SPECIAL_BIT  = 5;
  localparam int EFR_ENHANCED_BIT = 4;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int EFR_AUTO_CTS_BIT = 7;
  // Interrupt enable register bit positions
  localparam int IER_PAUSE_BIT    = 5;
  localparam int IER_RTS_BIT      = 6;
  localparam int IER_CTS_BIT      = 7;
  // Modem control bit that starts the request-to-send function
  localparam int MCR_RTS_BIT      = 1;
  // Software flow control field: [1:0] receive compare, [3:2] transmit
  localparam int SWFC_RX_LSB      = 0;
  localparam int SWFC_TX_LSB      = 2;

  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [4:0] COUNT_ZERO = 5'h00;

  // Trigger table steps
  localparam logic [4:0] TRIG_0  = 5'h00;
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;
  localparam logic [4:0] FIFO_FULL = 5'h10;

  // Character times to wait before sending pause characters
  localparam int PAUSE_DELAY_CHARS = 2;
  // Clock cycles per bit in a character frame (16x clocks per bit)
  localparam int CLKS_PER_BIT = 16;

  typedef enum logic [1:0] {
    UAFC_MODE_OFF    = 2'h0,
    UAFC_MODE_FIRST  = 2'h1,
    UAFC_MODE_SECOND = 2'h2,
    UAFC_MODE_DOUBLE = 2'h3
  } uafc_mode_type;

  typedef struct packed {
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
  } uafc_chars_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uafc_char_type;

endpackage : uafc_pkg

// ==== rtl/uafc_char_match.sv ====
`timescale 1ns/1ps
module uafc_char_match (
  input  wire logic [7:0] char_in,
  input  wire logic [7:0] pattern,
  input  wire logic [1:0] word_len,
  output logic            match
);
  import uafc_pkg::*;

  logic [7:0] len_mask;
  logic [7:0] diff;

  // Only the programmed word length takes part in the compare [R19]
  assign len_mask = (word_len == 2'h0) ? 8'h1f :
                    (word_len == 2'h1) ? 8'h3f :
                    (word_len == 2'h2) ? 8'h7f : 8'hff;
  assign diff     = (char_in ^ pattern) & len_mask;
  assign match    = (diff == 8'h00);

endmodule : uafc_char_match

// ==== rtl/uafc_flow_ctrl.sv ====
// Summary of operation
// R1: Automatic request-to-send works only with enhanced feature bit 6 set.
// R2: Host starts auto request-to-send by setting modem control bit 1.
// R3: Request-to-send rising, when enabled, sets status bit 5 and interrupts.
// R4: Receive interrupt at trigger; request-to-send high at next trigger up.
// R5: Request-to-send returns low when FIFO drains to one trigger below.
// R6: Receiver keeps filling FIFO while request-to-send is high.
// R7: Automatic clear-to-send works only with enhanced feature bit 7 set.
// R8: Clear-to-send going high, when enabled, sets status bit 5, interrupts.
// R9: Clear-to-send high stops transmitter after current stop bit.
// R10: Matched pause characters halt transmit after current character.
// R11: Pause match with enable bit 5 sets pause flag and interrupt.
// R12: After pause, resume character match restarts transmit, clears bit 4.
// R13: Reset clears all pause and resume characters to zero.
// R14: Double mode matches two consecutive characters in sequence.
// R15: Consumed flow-control characters never enter the receive FIFO.
// R16: Pause characters sent two character times after trigger crossing.
// R17: Resume characters sent when FIFO drops one trigger step below.
// R18: Special mode stores second-pause match in FIFO and sets bit 4.
// R19: Compares use programmed word length; bit 0 aligns with LSB.
// R20: After reset every automatic feature and interrupt is disabled.
`timescale 1ns/1ps
module uafc_flow_ctrl #(
  parameter int CHAR_CLKS = 10 * uafc_pkg::CLKS_PER_BIT
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic [7:0]               enhanced_feature_reg,
  input  wire logic [7:0]               interrupt_enable_reg,
  input  wire logic [7:0]               modem_control_reg,
  input  wire logic [1:0]               line_control_reg,
  input  wire logic [3:0]               sw_flow_mode,
  input  wire logic [4:0]               rx_trigger,
  input  wire logic [4:0]               rx_fifo_count,
  input  wire logic                     chars_write,
  input  wire uafc_pkg::uafc_chars_type chars_in,
  input  wire uafc_pkg::uafc_char_type  rx_char,
  input  wire logic                     cts_n,
  input  wire logic                     tx_char_done,
  input  wire logic                     tx_fc_ready,
  input  wire logic                     status_read,
  output uafc_pkg::uafc_char_type       rx_fifo_write,
  output uafc_pkg::uafc_char_type       tx_fc_char,
  output logic                          tx_enable,
  output logic                          rts_n,
  output logic                          rx_int,
  output logic                          modem_int,
  output logic                          pause_int,
  output logic [5:4]                    status_bits
);
  import uafc_pkg::*;

  localparam int CNT_W = $clog2(PAUSE_DELAY_CHARS * CHAR_CLKS + 1);
  localparam logic [CNT_W-1:0] PAUSE_WAIT =
    CNT_W'(PAUSE_DELAY_CHARS * CHAR_CLKS - 1);

  typedef enum logic [4:0] {
    UAFC_TX_IDLE      = 5'b00001,
    UAFC_TX_WAIT      = 5'b00010,
    UAFC_TX_PAUSED    = 5'b00100,
    UAFC_TX_SEND_P    = 5'b01000,
    UAFC_TX_SEND_R    = 5'b10000
  } uafc_send_type;

  uafc_chars_type     chars;
  uafc_send_type      send_state;
  uafc_send_type      next_send_state;
  uafc_mode_type      rx_mode;
  uafc_mode_type      tx_mode;
  logic [CNT_W-1:0]   wait_count;
  logic               send_second;
  logic               half_pause;
  logic               half_resume;
  logic               remote_paused;
  logic               rts_raised;
  logic               cts_prev;
  logic               rts_prev;
  logic [4:0]         trig_up;
  logic [4:0]         trig_down;
  logic               m_pf, m_ps, m_rf, m_rs;
  logic               auto_rts;
  logic               auto_cts;
  logic               enhanced;
  logic               special;
  logic               pause_hit;
  logic               resume_hit;
  logic               special_hit;
  logic               consumed;
  logic               first_half_hit;
  logic               rts_rise;
  logic               cts_rise;
  logic               next_rts_n;
  logic               next_tx_enable;
  logic [7:0]         send_data;
  logic               over_trigger;
  logic               under_resume;

  uafc_char_match u_pf (.char_in(rx_char.data),
    .pattern(chars.pause_char_first), .word_len(line_control_reg),
    .match(m_pf));
  uafc_char_match u_ps (.char_in(rx_char.data),
    .pattern(chars.pause_char_second), .word_len(line_control_reg),
    .match(m_ps));
  uafc_char_match u_rf (.char_in(rx_char.data),
    .pattern(chars.resume_char_first), .word_len(line_control_reg),
    .match(m_rf));
  uafc_char_match u_rs (.char_in(rx_char.data),
    .pattern(chars.resume_char_second), .word_len(line_control_reg),
    .match(m_rs));

  assign rx_mode  = uafc_mode_type'(sw_flow_mode[SWFC_RX_LSB +: 2]);
  assign tx_mode  = uafc_mode_type'(sw_flow_mode[SWFC_TX_LSB +: 2]);
  assign auto_rts = enhanced_feature_reg[EFR_AUTO_RTS_BIT];      // [R1]
  assign auto_cts = enhanced_feature_reg[EFR_AUTO_CTS_BIT];      // [R7]
  assign enhanced = enhanced_feature_reg[EFR_ENHANCED_BIT];
  assign special  = enhanced_feature_reg[EFR_SPECIAL_BIT];

  // One step up and one step down the trigger table
  assign trig_up   = (rx_trigger == TRIG_1) ? TRIG_4  :
                     (rx_trigger == TRIG_4) ? TRIG_8  :
                     (rx_trigger == TRIG_8) ? TRIG_14 : FIFO_FULL;
  assign trig_down = (rx_trigger == TRIG_1) ? TRIG_0 :
                     (rx_trigger == TRIG_4) ? TRIG_1 :
                     (rx_trigger == TRIG_8) ? TRIG_4 : TRIG_8;

  // Character matching, single or double depending on mode [R10] [R14]
  always_comb begin
    pause_hit      = 1'b0;
    resume_hit     = 1'b0;
    first_half_hit = 1'b0;
    unique case (rx_mode)
      UAFC_MODE_OFF: begin
      end
      UAFC_MODE_FIRST: begin
        pause_hit  = m_pf;
        resume_hit = m_rf;
      end
      UAFC_MODE_SECOND: begin
        pause_hit  = m_ps;
        resume_hit = m_rs;
      end
      UAFC_MODE_DOUBLE: begin
        pause_hit      = half_pause & m_ps;                    // [R14]
        resume_hit     = half_resume & m_rs;                   // [R14]
        first_half_hit = m_pf | m_rf;
      end
    endcase
  end

  // Special detect is independent of pause handling [R18]
  assign special_hit = rx_char.valid & special & m_ps;
  // A lone first half of a double pair is swallowed; if the second half
  // does not match, it is lost, as keeping it needs a holding buffer.
  assign consumed = rx_char.valid & ~special_hit &
                    (pause_hit | resume_hit | first_half_hit);  // [R15]

  assign rts_rise = ~rts_prev & rts_n;
  assign cts_rise = ~cts_prev & cts_n;

  // Hysteresis on request-to-send [R4] [R5] [R2]
  always_comb begin
    next_rts_n = 1'b1;
    if (modem_control_reg[MCR_RTS_BIT]) begin                  // [R2]
      next_rts_n = 1'b0;
      if (auto_rts) begin
        if (rx_fifo_count >= trig_up) begin                    // [R4]
          next_rts_n = 1'b1;
        end else if (rts_raised && rx_fifo_count > trig_down) begin
          next_rts_n = 1'b1;                                   // [R5]
        end
      end
    end
  end

  assign over_trigger = rx_fifo_count >= rx_trigger;
  assign under_resume = (rx_fifo_count <= trig_down);          // [R17]

  always_comb begin
    next_send_state = send_state;
    unique case (send_state)
      UAFC_TX_IDLE:
        if (tx_mode != UAFC_MODE_OFF && over_trigger) begin
          next_send_state = UAFC_TX_WAIT;
        end
      UAFC_TX_WAIT:
        if (!over_trigger) begin
          next_send_state = UAFC_TX_IDLE;
        end else if (wait_count == PAUSE_WAIT) begin           // [R16]
          next_send_state = UAFC_TX_SEND_P;
        end
      UAFC_TX_SEND_P:
        if (tx_fc_ready && (send_second ||
            tx_mode != UAFC_MODE_DOUBLE)) begin
          next_send_state = UAFC_TX_PAUSED;
        end
      UAFC_TX_PAUSED:
        if (under_resume) begin
          next_send_state = UAFC_TX_SEND_R;                    // [R17]
        end
      UAFC_TX_SEND_R:
        if (tx_fc_ready && (send_second ||
            tx_mode != UAFC_MODE_DOUBLE)) begin
          next_send_state = UAFC_TX_IDLE;
        end
    endcase
  end

  assign send_data = (next_send_state == UAFC_TX_SEND_P) ?
    ((send_second || tx_mode == UAFC_MODE_SECOND) ?
      chars.pause_char_second : chars.pause_char_first) :
    ((send_second || tx_mode == UAFC_MODE_SECOND) ?
      chars.resume_char_second : chars.resume_char_first);

  // Transmit gate closes only at a character boundary; it reopens in any cycle [R9] [R10]
  assign next_tx_enable = ~((auto_cts & cts_n) | remote_paused);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chars <= {CHAR_RESET, CHAR_RESET, CHAR_RESET, CHAR_RESET}; // [R13]
    end else if (chars_write) begin
      chars <= chars_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_pause  <= 1'b0;
      half_resume <= 1'b0;
    end else if (rx_char.valid) begin
      half_pause  <= m_pf;                                     // [R14]
      half_resume <= m_rf;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remote_paused <= 1'b0;
    end else if (rx_char.valid && pause_hit) begin
      remote_paused <= 1'b1;                                   // [R10]
    end else if (rx_char.valid && resume_hit) begin
      remote_paused <= 1'b0;                                   // [R12]
    end else if (rx_mode == UAFC_MODE_OFF) begin
      remote_paused <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_enable   <= 1'b1;
    end else if (tx_char_done || !tx_enable) begin
      tx_enable   <= next_tx_enable;                           // [R9]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rts_n      <= 1'b1;
      rts_raised <= 1'b0;
      rts_prev   <= 1'b1;
      cts_prev   <= 1'b1;
    end else begin
      rts_n      <= next_rts_n;
      rts_raised <= next_rts_n & auto_rts & modem_control_reg[MCR_RTS_BIT];
      rts_prev   <= rts_n;
      cts_prev   <= cts_n;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      send_state  <= UAFC_TX_IDLE;
      wait_count  <= '0;
      send_second <= 1'b0;
    end else begin
      send_state <= next_send_state;
      if (send_state == UAFC_TX_WAIT) begin
        wait_count <= wait_count + CNT_W'(1);                  // [R16]
      end else begin
        wait_count <= '0;
      end
      if (next_send_state != send_state) begin
        send_second <= 1'b0;
      end else if (tx_fc_ready && tx_fc_char.valid) begin
        send_second <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_fc_char <= '0;
    end else begin
      tx_fc_char.valid <= (next_send_state == UAFC_TX_SEND_P ||
                           next_send_state == UAFC_TX_SEND_R) &&
                          !(tx_fc_ready && tx_fc_char.valid);
      tx_fc_char.data  <= send_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_fifo_write <= '0;
    end else begin
      // Full FIFO drops the character; flow control never blocks it [R6]
      rx_fifo_write.valid <= rx_char.valid & ~consumed &
                             (rx_fifo_count < FIFO_FULL);      // [R15]
      rx_fifo_write.data  <= rx_char.data;
    end
  end

  // Status bits: hardware set wins over a read clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_bits <= 2'b00;                                    // [R20]
      modem_int   <= 1'b0;
      pause_int   <= 1'b0;
      rx_int      <= 1'b0;
    end else begin
      rx_int <= auto_rts & over_trigger;                       // [R4]
      if ((enhanced && interrupt_enable_reg[IER_RTS_BIT] &&
           auto_rts && rts_rise) ||                            // [R3]
          (enhanced && interrupt_enable_reg[IER_CTS_BIT] &&
           auto_cts && cts_rise)) begin                        // [R8]
        status_bits[5] <= 1'b1;
        modem_int      <= 1'b1;
      end else if (status_read) begin
        status_bits[5] <= 1'b0;
        modem_int      <= 1'b0;
      end
      if (special_hit ||
          (rx_char.valid && pause_hit &&
           interrupt_enable_reg[IER_PAUSE_BIT])) begin         // [R11] [R18]
        status_bits[4] <= 1'b1;
        pause_int      <= 1'b1;
      end else if ((rx_char.valid && resume_hit) || status_read) begin
        status_bits[4] <= 1'b0;                                // [R12]
        pause_int      <= 1'b0;
      end
    end
  end

endmodule : uafc_flow_ctrl

// ==== testbench/uafc_flow_ctrl_props.sv ====
`timescale 1ns/1ps
module uafc_flow_ctrl_props (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic [7:0]              enhanced_feature_reg,
  input wire logic [7:0]              interrupt_enable_reg,
  input wire logic [7:0]              modem_control_reg,
  input wire logic [3:0]              sw_flow_mode,
  input wire logic [4:0]              rx_trigger,
  input wire logic [4:0]              rx_fifo_count,
  input wire uafc_pkg::uafc_char_type rx_char,
  input wire logic                    cts_n,
  input wire logic                    tx_char_done,
  input wire logic                    tx_fc_ready,
  input wire uafc_pkg::uafc_char_type rx_fifo_write,
  input wire uafc_pkg::uafc_char_type tx_fc_char,
  input wire logic                    tx_enable,
  input wire logic                    rts_n,
  input wire logic                    rx_int,
  input wire logic                    modem_int,
  input wire logic [5:4]              status_bits
);
  import uafc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire auto_rts = enhanced_feature_reg[6] && modem_control_reg[1];
  sequence s_cts_held;
    (enhanced_feature_reg[7] && cts_n) [*2];
  endsequence
  property p_rts_off;
    !modem_control_reg[1] |=> rts_n;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("rts_n active");
  property p_rts_high;
    auto_rts && rx_trigger == TRIG_4 && rx_fifo_count >= TRIG_8 |=> rts_n;
  endproperty
  a_rts_high: assert property (p_rts_high)
    else $error("rts_n not raised");
  property p_rts_low;
    auto_rts && rx_trigger == TRIG_4 && rx_fifo_count <= TRIG_1 |=> !rts_n;
  endproperty
  a_rts_low: assert property (p_rts_low)
    else $error("rts_n not lowered");
  property p_rx_int;
    auto_rts && rx_trigger != TRIG_0 && rx_fifo_count >= rx_trigger
      |=> rx_int;
  endproperty
  a_rx_int: assert property (p_rx_int) else $error("rx_int missing");
  property p_pass;
    rx_char.valid && sw_flow_mode[1:0] == 2'h0 && rx_fifo_count < FIFO_FULL
      |=> rx_fifo_write.valid && rx_fifo_write.data == $past(rx_char.data);
  endproperty
  a_pass: assert property (p_pass) else $error("char not stored");
  property p_cause;
    rx_fifo_write.valid |-> $past(rx_char.valid);
  endproperty
  a_cause: assert property (p_cause)
    else $error("write without char");
  property p_full;
    rx_char.valid && rx_fifo_count >= FIFO_FULL |=> !rx_fifo_write.valid;
  endproperty
  a_full: assert property (p_full) else $error("write when full");
  property p_cts_int;
    $rose(cts_n) && enhanced_feature_reg[7] && enhanced_feature_reg[4]
      && interrupt_enable_reg[7] |-> ##[1:2] (status_bits[5] && modem_int);
  endproperty
  a_cts_int: assert property (p_cts_int)
    else $error("cts int missing");
  property p_cts_stop;
    s_cts_held ##0 tx_char_done |=> !tx_enable;
  endproperty
  a_cts_stop: assert property (p_cts_stop)
    else $error("tx not stopped");
  property p_fc_hold;
    tx_fc_char.valid && !tx_fc_ready
      |=> tx_fc_char.valid && $stable(tx_fc_char.data);
  endproperty
  a_fc_hold: assert property (p_fc_hold)
    else $error("flow char dropped");
endmodule : uafc_flow_ctrl_props

// ==== testbench/uafc_remote_model.sv ====
`timescale 1ns/1ps
module uafc_remote_model (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               send,
  input  wire logic [7:0]         send_data,
  input  wire logic               hold_off,
  output uafc_pkg::uafc_char_type rx_char,
  output logic                    cts_n
);
  import uafc_pkg::*;
  logic [7:0] last;
  // Idle data is the inverse of the last byte so stale data never matches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_char <= '0;
      last    <= CHAR_RESET;
      cts_n   <= 1'b0;
    end else begin
      rx_char.valid <= send;
      rx_char.data  <= send ? send_data : ~last;
      last          <= send ? send_data : last;
      cts_n         <= hold_off;
    end
  end
endmodule : uafc_remote_model

// ==== testbench/tb_uafc_flow_ctrl.sv ====
`timescale 1ns/1ps
module tb_uafc_flow_ctrl;
  import uafc_pkg::*;
  localparam int CCLK = 2;
  // Rows: trigger, count, expected rts_n, expected rx_int
  localparam logic [11:0] ROWS [19] = '{
    {5'h04, 5'h00, 2'h0}, {5'h04, 5'h04, 2'h1}, {5'h04, 5'h07, 2'h1},
    {5'h04, 5'h08, 2'h3}, {5'h04, 5'h05, 2'h3}, {5'h04, 5'h01, 2'h0},
    {5'h01, 5'h01, 2'h1}, {5'h01, 5'h04, 2'h3}, {5'h01, 5'h02, 2'h3},
    {5'h01, 5'h00, 2'h0}, {5'h08, 5'h08, 2'h1}, {5'h08, 5'h0e, 2'h3},
    {5'h08, 5'h05, 2'h2}, {5'h08, 5'h04, 2'h0}, {5'h0e, 5'h0e, 2'h1},
    {5'h0e, 5'h0f, 2'h1}, {5'h0e, 5'h10, 2'h3}, {5'h0e, 5'h09, 2'h2},
    {5'h0e, 5'h08, 2'h0}};
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic [7:0]     feat = 8'h00;
  logic [7:0]     int_en = 8'h00;
  logic [7:0]     modem_ctl = 8'h00;
  logic [1:0]     word_len = 2'h3;
  logic [3:0]     sw_mode = 4'h0;
  logic [4:0]     trig = TRIG_4;
  logic [4:0]     count = COUNT_ZERO;
  logic           chars_write = 1'b0;
  uafc_chars_type chars = '0;
  logic           tx_done = 1'b0;
  logic           fc_ready = 1'b0;
  logic           status_read = 1'b0;
  logic           send = 1'b0;
  logic [7:0]     send_data = 8'h00;
  logic           hold_off = 1'b0;
  uafc_char_type  rx_char;
  uafc_char_type  fifo_wr;
  uafc_char_type  fc_char;
  logic           cts_n;
  logic           tx_enable;
  logic           rts_n;
  logic           rx_int;
  logic           modem_int;
  logic           pause_int;
  logic [5:4]     status_bits;
  int             mismatches = 0;
  int             comparisons = 0;
  always #12.5 clk = ~clk;
  uafc_remote_model i_uafc_remote_model (.clk(clk), .reset_n(reset_n),
    .send(send), .send_data(send_data), .hold_off(hold_off),
    .rx_char(rx_char), .cts_n(cts_n));
  uafc_flow_ctrl #(.CHAR_CLKS(CCLK)) i_uafc_flow_ctrl (.clk(clk),
    .reset_n(reset_n), .enhanced_feature_reg(feat),
    .interrupt_enable_reg(int_en), .modem_control_reg(modem_ctl),
    .line_control_reg(word_len), .sw_flow_mode(sw_mode),
    .rx_trigger(trig), .rx_fifo_count(count), .chars_write(chars_write),
    .chars_in(chars), .rx_char(rx_char), .cts_n(cts_n),
    .tx_char_done(tx_done), .tx_fc_ready(fc_ready),
    .status_read(status_read), .rx_fifo_write(fifo_wr),
    .tx_fc_char(fc_char), .tx_enable(tx_enable), .rts_n(rts_n),
    .rx_int(rx_int), .modem_int(modem_int), .pause_int(pause_int),
    .status_bits(status_bits));
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // Stored flag sampled one cycle after the model hands the char over
  task automatic rx_chk(input logic [7:0] d, input logic wr);
    send_data = d;
    pulse(send);
    cyc(1);
    chk({7'h00, fifo_wr.valid}, {7'h00, wr});
  endtask : rx_chk
  task automatic wait_fc(input logic [7:0] exp);
    int n;
    n = 0;
    while (fc_char.valid !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) begin
      mismatches++;
      wrap_up();
    end
    chk(fc_char.data, exp);
  endtask : wait_fc
  initial begin
    cyc(6);
    reset_n = 1'b1;
    cyc(2);
    chk({1'b0, rts_n, tx_enable, rx_int, modem_int, pause_int,
         status_bits}, 8'h60);
    chk({6'h00, fifo_wr.valid, fc_char.valid}, 8'h00);
    $display("reset test done");
    feat = 8'h50;
    int_en = 8'h40;
    modem_ctl = 8'h02;
    foreach (ROWS[i]) begin
      {trig, count} = ROWS[i][11:2];
      cyc(2);
      chk({6'h00, rts_n, rx_int}, {6'h00, ROWS[i][1:0]});
    end
    chk({6'h00, modem_int, status_bits[5]}, 8'h03);
    pulse(status_read);
    cyc(1);
    chk({6'h00, modem_int, status_bits[5]}, 8'h00);
    trig = TRIG_8;
    count = 5'h0c;
    cyc(2);
    rx_chk(8'h5a, 1'b1);
    chk(fifo_wr.data, 8'h5a);
    count = FIFO_FULL;
    rx_chk(8'h5b, 1'b0);
    feat = 8'h10;
    cyc(2);
    chk({7'h00, rts_n}, 8'h00);
    modem_ctl = 8'h00;
    count = COUNT_ZERO;
    cyc(2);
    chk({7'h00, rts_n}, 8'h01);
    $display("rts test done");
    pulse(status_read);
    hold_off = 1'b1;
    cyc(3);
    pulse(tx_done);
    cyc(1);
    chk({7'h00, tx_enable}, 8'h01);
    hold_off = 1'b0;
    feat = 8'h90;
    int_en = 8'h80;
    cyc(2);
    hold_off = 1'b1;
    cyc(3);
    chk({6'h00, modem_int, status_bits[5]}, 8'h03);
    pulse(tx_done);
    cyc(1);
    chk({7'h00, tx_enable}, 8'h00);
    hold_off = 1'b0;
    cyc(3);
    chk({7'h00, tx_enable}, 8'h01);
    pulse(status_read);
    feat = 8'h10;
    int_en = 8'h20;
    sw_mode = 4'h1;
    rx_chk(8'h00, 1'b0);
    chk({7'h00, status_bits[4]}, 8'h01);
    pulse(status_read);
    chars = {8'h11, 8'h12, 8'h13, 8'h14};
    pulse(chars_write);
    for (int m = 1; m < 4; m++) begin
      sw_mode = 4'(m);
      if (m != 2) rx_chk(8'h13, 1'b0);
      if (m != 1) rx_chk(8'h14, 1'b0);
      chk({6'h00, pause_int, status_bits[4]}, 8'h03);
      pulse(tx_done);
      cyc(1);
      chk({7'h00, tx_enable}, 8'h00);
      if (m != 2) rx_chk(8'h11, 1'b0);
      if (m != 1) rx_chk(8'h12, 1'b0);
      cyc(1);
      chk({6'h00, tx_enable, status_bits[4]}, 8'h02);
      pulse(status_read);
    end
    word_len = 2'h0;
    sw_mode = 4'h1;
    rx_chk(8'hf3, 1'b0);
    rx_chk(8'h31, 1'b0);
    word_len = 2'h3;
    sw_mode = 4'h0;
    pulse(status_read);
    $display("software flow test done");
    feat = 8'h30;
    rx_chk(8'h14, 1'b1);
    chk({7'h00, status_bits[4]}, 8'h01);
    pulse(status_read);
    $display("special char test done");
    feat = 8'h10;
    sw_mode = 4'h4;
    trig = TRIG_4;
    count = TRIG_4;
    cyc(2 * CCLK);
    chk({7'h00, fc_char.valid}, 8'h00);
    cyc(1);
    chk({7'h00, fc_char.valid}, 8'h01);
    wait_fc(8'h13);
    cyc(2);
    pulse(fc_ready);
    count = TRIG_1;
    wait_fc(8'h11);
    pulse(fc_ready);
    sw_mode = 4'hc;
    count = TRIG_4;
    wait_fc(8'h13);
    pulse(fc_ready);
    wait_fc(8'h14);
    pulse(fc_ready);
    count = TRIG_1;
    wait_fc(8'h11);
    pulse(fc_ready);
    wait_fc(8'h12);
    pulse(fc_ready);
    $display("flow char send test done");
    wrap_up();
  end
endmodule : tb_uafc_flow_ctrl
bind uafc_flow_ctrl uafc_flow_ctrl_props i_uafc_flow_ctrl_props (
  .clk(clk), .reset_n(reset_n), .enhanced_feature_reg(enhanced_feature_reg),
  .interrupt_enable_reg(interrupt_enable_reg),
  .modem_control_reg(modem_control_reg), .sw_flow_mode(sw_flow_mode),
  .rx_trigger(rx_trigger), .rx_fifo_count(rx_fifo_count),
  .rx_char(rx_char), .cts_n(cts_n), .tx_char_done(tx_char_done),
  .tx_fc_ready(tx_fc_ready), .rx_fifo_write(rx_fifo_write),
  .tx_fc_char(tx_fc_char), .tx_enable(tx_enable), .rts_n(rts_n),
  .rx_int(rx_int), .modem_int(modem_int), .status_bits(status_bits));
